// ==== verification/controller_model.sv ====
// Camera controller model: row and frame pulses, converter data, pixel counts.
`timescale 1ns/1ps
`default_nettype none
module controller_model (
  // Clock, reset and requests
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        row_go,
  input  wire logic        frame_go,
  // Pins towards the sensor
  output logic             row_clock_pin,
  output logic             frame_start_pin,
  output logic [9:0]       even_adc_data,
  output logic [9:0]       odd_adc_data,
  // Pixel stream back from the sensor
  input  wire logic        pixel_valid,
  input  wire logic        pixel_odd,
  output logic [15:0]      n_pix,
  output logic [15:0]      n_odd
);
  // ------------------------------------------------------------
  // Behaviour
  // ------------------------------------------------------------
  logic [2:0] hold;
  // Row pulses stay high four cycles so the two-stage synchroniser cannot miss them; frame pulses last one cycle while hold is zero.
  always_ff @(posedge clock) begin
    if (reset) begin
      hold <= 3'h0;
      frame_start_pin <= 1'b0;
      even_adc_data <= 10'h000;
      n_pix <= 16'h0000;
      n_odd <= 16'h0000;
    end else begin
      hold <= row_go ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : hold);
      frame_start_pin <= frame_go || (frame_start_pin && hold > 3'h1);
      even_adc_data <= even_adc_data + 10'h001;
      n_pix <= n_pix + {15'h0000, pixel_valid};
      n_odd <= n_odd + {15'h0000, pixel_valid && pixel_odd};
    end
  end
  assign row_clock_pin = hold != 3'h0;
  assign odd_adc_data = ~even_adc_data;
endmodule
`default_nettype wire

// ==== verification/readout_path_properties.sv ====
// Port-level assertions and covers for the readout path.
`timescale 1ns/1ps
`default_nettype none
module readout_path_properties
  import readout_path_pkg::*;
(
  // Clock, reset and register port
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  // Analog path controls
  input wire logic        amp_standby,
  input wire logic        second_path_standby,
  input wire logic        merge_outputs,
  input wire logic [3:0]  gain_code,
  input wire logic [7:0]  fine_offset_code,
  input wire logic        dark_to_buses,
  input wire logic        reset_lines_to_fine
);
  // ------------------------------------------------------------
  // Decodes and properties
  // ------------------------------------------------------------
  wire logic wr_amp  = reg_write && (reg_addr == addr_amplifier);
  wire logic wr_gain = reg_write && (reg_addr == addr_gain);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  reset_dual_a: assert property (disable iff (1'b0)
    reset |=> !merge_outputs && !amp_standby) else $error("Not dual output after reset.");
  merge_write_a: assert property (
    wr_amp |=> merge_outputs == $past(reg_wdata[amp_one_out_bit])) else $error("Merge wrong.");
  second_idle_a: assert property (
    second_path_standby == (amp_standby || merge_outputs)) else $error("Second path wrong.");
  standby_write_a: assert property (
    wr_amp |=> amp_standby == $past(reg_wdata[amp_standby_bit])) else $error("Standby wrong.");
  gain_write_a: assert property (
    wr_gain |=> gain_code == $past(reg_wdata[3:0])) else $error("Gain wrong.");
  gain_hold_a: assert property (
    !wr_gain |=> $stable(gain_code)) else $error("Gain moved without write.");
  fine_write_a: assert property (
    reg_write && reg_addr == addr_dac_fine |=> fine_offset_code == $past(reg_wdata[7:0]))
    else $error("Fine offset wrong.");
  calib_dark_a: assert property (
    wr_amp |=> dark_to_buses == $past(reg_wdata[amp_calib_bit])) else $error("Dark wrong.");
  ndr_ties_a: assert property (
    reg_write && reg_addr == addr_core |=> reset_lines_to_fine == $past(reg_wdata[core_ndr_bit]))
    else $error("Reset lines wrong.");
  read_gain_a: assert property (
    reg_read && reg_addr == addr_gain |=> reg_rdata == {12'h000, gain_code})
    else $error("Gain readback wrong.");
  cover property (wr_amp ##1 merge_outputs);
  cover property (reset_lines_to_fine && dark_to_buses);
  cover property (wr_gain ##1 gain_code == 4'hF);
endmodule
bind readout_path readout_path_properties i_props (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .amp_standby(amp_standby), .second_path_standby(second_path_standby),
  .merge_outputs(merge_outputs), .gain_code(gain_code), .fine_offset_code(fine_offset_code),
  .dark_to_buses(dark_to_buses), .reset_lines_to_fine(reset_lines_to_fine));
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking testbench for the readout path.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import readout_path_pkg::*;
;
  // ------------------------------------------------------------
  // Signals, design and partner
  // ------------------------------------------------------------
  logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic row_go = 1'b0, frame_go = 1'b0, row_clock_pin, frame_start_pin;
  logic amp_standby, second_path_standby, merge_outputs, dark_to_buses, reset_lines_to_fine;
  logic pixel_valid, pixel_odd;
  logic [3:0] reg_addr = 4'h0, gain_code;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, n_pix, n_odd, p0, o0, ev;
  logic [7:0] coarse_offset_code, fine_offset_code, dark_code, d;
  logic [9:0] even_adc_data, odd_adc_data, pixel_data, prev_even;
  logic column_select, row_select, two_conv = 1'b1;
  logic [15:0] n_col = 16'h0000, c0;
  logic [11:0] ey = 12'h000;
  int num_errors = 0, n_tests = 0, seed = 22830;
  always #50 clock = ~clock;
  readout_path #(.pixels_per_line(24), .adc_bits(10)) i_readout_path (.clock(clock),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .row_clock_pin(row_clock_pin),
    .frame_start_pin(frame_start_pin), .even_adc_data(even_adc_data),
    .odd_adc_data(odd_adc_data), .amp_standby(amp_standby),
    .second_path_standby(second_path_standby), .merge_outputs(merge_outputs),
    .gain_code(gain_code), .coarse_offset_code(coarse_offset_code),
    .fine_offset_code(fine_offset_code), .dark_code(dark_code), .dark_to_buses(dark_to_buses),
    .reset_lines_to_fine(reset_lines_to_fine), .column_pair(), .column_select(column_select),
    .row_address(), .row_select(row_select), .pixel_data(pixel_data), .pixel_valid(pixel_valid),
    .pixel_odd(pixel_odd));
  controller_model i_controller_model (.clock(clock), .reset(reset), .row_go(row_go),
    .frame_go(frame_go), .row_clock_pin(row_clock_pin), .frame_start_pin(frame_start_pin),
    .even_adc_data(even_adc_data), .odd_adc_data(odd_adc_data), .pixel_valid(pixel_valid),
    .pixel_odd(pixel_odd), .n_pix(n_pix), .n_odd(n_odd));
  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // One idle edge lets the written value settle before the caller looks at it.
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    chk(reg_rdata, exp);
  endtask
  function automatic int step_of(input logic [2:0] c);
    return c[2] ? 12 : 2 * (int'(c[1:0]) + 1);
  endfunction
  function automatic logic [15:0] pix_per_line(input logic [2:0] c);
    return 16'(48 / step_of(c));
  endfunction
  // Each pixel carries the converter word of the cycle before it; odd pixels
  // come from the odd converter only while both converters are in use.
  always @(posedge clock) begin
    prev_even <= even_adc_data;
    n_col     <= n_col + {15'h0000, column_select};
    if (!reset && pixel_valid) begin
      chk({6'h00, pixel_data}, {6'h00, (two_conv && pixel_odd) ? ~prev_even : prev_even});
    end
  end
  task automatic stop_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(addr_amplifier, {12'h000, amp_reset});
    chk({15'h0000, merge_outputs}, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      wr(addr_gain, 16'(i));
      chk({12'h000, gain_code}, 16'(i));
    end
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : 8'($random(seed)));
      wr(addr_dac_coarse, {8'h00, d});
      wr(addr_dac_fine, {8'h00, ~d});
      wr(addr_dac_dark, {8'h00, d ^ 8'h5A});
      chk({coarse_offset_code, fine_offset_code}, {d, ~d});
      chk({8'h00, dark_code}, {8'h00, d ^ 8'h5A});
    end
    for (int m = 0; m < 16; m++) begin
      wr(addr_amplifier, 16'(m));
      chk({12'h000, amp_standby, merge_outputs, second_path_standby, dark_to_buses},
          {12'h000, m[0], m[1], m[0] | m[1], m[2]});
    end
    wr(addr_amplifier, {12'h000, amp_reset});
    wr(4'hF, 16'($random(seed)));
    rd(4'hF, 16'h0000);
    rd(addr_gain, 16'h000F);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(addr_gain, {12'h000, gain_reset});
    rd(addr_amplifier, {12'h000, amp_reset});
    chk({15'h0000, merge_outputs}, 16'h0000);
    wr(addr_start_x, 16'd120);
    rd(addr_start_x, {9'h000, start_x_last});
    wr(addr_start_y, 16'd200);
    rd(addr_start_y, {8'h00, start_y_last});
    wr(addr_start_x, 16'h0000);
    wr(addr_start_y, 16'h0005);
    frame_go <= 1'b1;
    @(posedge clock);
    frame_go <= 1'b0;
    repeat (20) @(posedge clock);
    for (int c = 0; c < 8; c++) begin
      // The upper modes run on one converter with the merged output.
      two_conv = (c < 4);
      wr(addr_amplifier, two_conv ? {12'h000, amp_reset} : 16'h0002);
      wr(addr_core, 16'(c * 2 + c % 2));
      chk({15'h0000, reset_lines_to_fine}, 16'(c % 2));
      rd(addr_core, 16'(c * 2 + c % 2));
      ev = pix_per_line(3'(c));
      p0 = n_pix;
      o0 = n_odd;
      c0 = n_col;
      ey = (c == 0) ? 12'h005 :
           ((c % 2 == 1) ? ey + 12'h001 : ey + 12'(step_of(3'(c))) - 12'h001);
      row_go <= 1'b1;
      @(posedge clock);
      row_go <= 1'b0;
      for (int k = 0; k < 300 && n_pix - p0 < ev; k++) @(posedge clock);
      if (n_pix - p0 < ev) begin
        num_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, n_pix - p0, ev);
        break;
      end
      repeat (40) @(posedge clock);
      chk(n_pix - p0, ev);
      chk(n_odd - o0, ev / 2);
      chk(n_col - c0, ev / 2);
      rd(addr_status, {4'h0, ey});
    end
    chk({15'h0000, row_select}, 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire

// ==== verilog/readout_path.sv ====
// Output amplifier control, converter routing and sub-sampled line readout.
//
// Behaviour
// - After reset, amplifier runs dual-output mode
// - Single-output bit merges both paths onto first
// - Single-output mode puts second path stages standby
// - Standby bit powers down whole output amplifier
// - Four-bit gain code drives gain stage
// - Offset DACs take eight-bit monotonic codes
// - Coarse sets black level, fine shifts second
// - Calibration drives dark DAC onto buses
// - Nondestructive readout ties reset lines to fine
// - Two converters split even and odd columns
// - One converter may digitise all pixels
// - Sub-sampling code selects step 2/4/6/8/12
// - Each step reads two adjacent pixels
// - Pattern repeats over 24-pixel block
// - 99 horizontal, 138 vertical start coordinates
// - Columns addressed in odd/even pairs
// - Rows addressed singly
// - Merged output runs full pixel rate
// - Dual output uses two separate pins
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module readout_path
  import readout_path_pkg::*;
#(
  parameter int pixels_per_line = 2222,
  parameter int adc_bits        = 10
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // Register port
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [15:0]         reg_rdata,
  // Controller timing pins
  input  wire logic                row_clock_pin,
  input  wire logic                frame_start_pin,
  // Converter results, even and odd columns
  input  wire logic [adc_bits-1:0] even_adc_data,
  input  wire logic [adc_bits-1:0] odd_adc_data,
  // Analog path controls
  output logic                     amp_standby,
  output logic                     second_path_standby,
  output logic                     merge_outputs,
  output logic [3:0]               gain_code,
  output logic [7:0]               coarse_offset_code,
  output logic [7:0]               fine_offset_code,
  output logic [7:0]               dark_code,
  output logic                     dark_to_buses,
  output logic                     reset_lines_to_fine,
  // Array addressing
  output logic [10:0]              column_pair,
  output logic                     column_select,
  output logic [11:0]              row_address,
  output logic                     row_select,
  // Digitised pixel stream
  output logic [adc_bits-1:0]      pixel_data,
  output logic                     pixel_valid,
  output logic                     pixel_odd
);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [3:0] amp_cfg;
  logic [3:0] core_cfg;
  logic [6:0] start_x;
  logic [7:0] start_y;

  wire wr_amp    = reg_write && reg_addr == addr_amplifier;
  wire wr_gain   = reg_write && reg_addr == addr_gain;
  wire wr_coarse = reg_write && reg_addr == addr_dac_coarse;
  wire wr_fine   = reg_write && reg_addr == addr_dac_fine;
  wire wr_dark   = reg_write && reg_addr == addr_dac_dark;
  wire wr_core   = reg_write && reg_addr == addr_core;
  wire wr_sx     = reg_write && reg_addr == addr_start_x;
  wire wr_sy     = reg_write && reg_addr == addr_start_y;

  // Start indices beyond the last coordinate are clamped rather than wrapped.
  wire [6:0] sx_in = (reg_wdata[6:0] > start_x_last) ? start_x_last : reg_wdata[6:0];
  wire [7:0] sy_in = (reg_wdata[7:0] > start_y_last) ? start_y_last : reg_wdata[7:0];

  always_ff @(posedge clock) begin
    if (reset) begin
      amp_cfg            <= amp_reset;
      gain_code          <= gain_reset;
      coarse_offset_code <= dac_reset;
      fine_offset_code   <= dac_reset;
      dark_code          <= dac_reset;
      core_cfg           <= core_reset;
      start_x            <= 7'h00;
      start_y            <= 8'h00;
    end else begin
      if (wr_amp)    amp_cfg            <= reg_wdata[3:0];
      if (wr_gain)   gain_code          <= reg_wdata[3:0];
      if (wr_coarse) coarse_offset_code <= reg_wdata[7:0];
      if (wr_fine)   fine_offset_code   <= reg_wdata[7:0];
      if (wr_dark)   dark_code          <= reg_wdata[7:0];
      if (wr_core)   core_cfg           <= reg_wdata[3:0];
      if (wr_sx)     start_x            <= sx_in;
      if (wr_sy)     start_y            <= sy_in;
    end
  end

  // ---------------------------------------------------------------
  // Analog path decode
  // ---------------------------------------------------------------
  wire standby_bit = amp_cfg[amp_standby_bit];
  wire one_out     = amp_cfg[amp_one_out_bit];
  wire two_adc     = amp_cfg[amp_two_adc_bit];
  wire ndr_on      = core_cfg[core_ndr_bit];
  wire [2:0] sub_code = core_cfg[core_sub_lsb +: 3];

  assign amp_standby         = standby_bit;
  assign merge_outputs       = one_out;
  assign second_path_standby = standby_bit | one_out;
  assign dark_to_buses       = amp_cfg[amp_calib_bit];
  assign reset_lines_to_fine = ndr_on;

  // ---------------------------------------------------------------
  // Sub-sampling step decode
  // ---------------------------------------------------------------
  logic [4:0] step;
  always_comb begin
    case (sub_code)
      3'b000:  step = step_a;
      3'b001:  step = step_b;
      3'b010:  step = step_c;
      3'b011:  step = step_d;
      default: step = step_e;
    endcase
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and row clock edge
  // ---------------------------------------------------------------
  logic [1:0] row_sync;
  logic [1:0] frame_sync;
  logic       row_prev;
  logic       frame_prev;
  always_ff @(posedge clock) begin
    if (reset) begin
      row_sync   <= 2'b00;
      frame_sync <= 2'b00;
      row_prev   <= 1'b0;
      frame_prev <= 1'b0;
    end else begin
      row_sync   <= {row_sync[0], row_clock_pin};
      frame_sync <= {frame_sync[0], frame_start_pin};
      row_prev   <= row_sync[1];
      frame_prev <= frame_sync[1];
    end
  end
  wire row_pulse   = row_sync[1] & ~row_prev;
  wire frame_pulse = frame_sync[1] & ~frame_prev;

  // ---------------------------------------------------------------
  // Vertical pointer: single rows, step rows per sub-sampling period
  // ---------------------------------------------------------------
  logic [4:0] row_phase;
  wire [11:0] y_base = {4'h0, start_y};
  always_ff @(posedge clock) begin
    if (reset) begin
      row_address <= 12'h000;
      row_phase   <= 5'h00;
      row_select  <= 1'b0;
    end else if (frame_pulse) begin
      row_address <= y_base;
      row_phase   <= 5'h00;
      row_select  <= 1'b0;
    end else if (row_pulse) begin
      row_select <= 1'b1;
      // The first pulse of a frame selects the start row itself, so it is not skipped.
      // After that two adjacent rows are read, then the rest of the step is skipped.
      if (!row_select) begin
        row_phase <= 5'h01;
      end else if (row_phase == 5'h01) begin
        row_address <= row_address + 12'h001;
        row_phase   <= 5'h00;
      end else begin
        row_address <= row_address + 12'(step) - 12'h001;
        row_phase   <= 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Horizontal pointer: column pairs from a 24-pixel aligned start
  // ---------------------------------------------------------------
  line_state_e state;
  logic [10:0] pairs_left;
  logic [4:0]  block_pos;
  logic        half;
  wire  [10:0] x_base = 11'(start_x) * 11'(block_width / 2);

  always_ff @(posedge clock) begin
    if (reset) begin
      state         <= line_idle;
      column_pair   <= 11'h000;
      column_select <= 1'b0;
      pairs_left    <= 11'h000;
      block_pos     <= 5'h00;
      half          <= 1'b0;
    end else begin
      case (state)
        line_idle: begin
          column_select <= 1'b0;
          if (row_pulse) begin
            column_pair <= x_base;
            pairs_left  <= 11'(pixels_per_line / 2);
            block_pos   <= 5'h00;
            half        <= 1'b0;
            state       <= line_read;
          end
        end
        line_read: begin
          column_select <= 1'b1;
          half          <= ~half;
          if (half) begin
            // One pair read; jump over the rest of the step within the block.
            column_select <= 1'b0;
            pairs_left    <= pairs_left - 11'(step >> 1);
            column_pair   <= column_pair + 11'(step >> 1);
            block_pos     <= (5'(block_pos + step) >= 5'(block_width)) ?
                             5'(block_pos + step - 5'(block_width)) :
                             5'(block_pos + step);
            state         <= (pairs_left <= 11'(step >> 1)) ? line_idle : line_read;
          end
        end
        line_skip: state <= line_idle;
        default:   state <= line_idle;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Converter routing: even/odd interleave or single converter
  // ---------------------------------------------------------------
  wire use_odd_adc = two_adc & half;
  always_ff @(posedge clock) begin
    if (reset) begin
      pixel_data  <= '0;
      pixel_valid <= 1'b0;
      pixel_odd   <= 1'b0;
    end else begin
      pixel_valid <= state == line_read;
      pixel_odd   <= half;
      pixel_data  <= use_odd_adc ? odd_adc_data : even_adc_data;
    end
  end

  // ---------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      addr_amplifier:  rd_mux = {12'h000, amp_cfg};
      addr_gain:       rd_mux = {12'h000, gain_code};
      addr_dac_coarse: rd_mux = {8'h00, coarse_offset_code};
      addr_dac_fine:   rd_mux = {8'h00, fine_offset_code};
      addr_dac_dark:   rd_mux = {8'h00, dark_code};
      addr_core:       rd_mux = {12'h000, core_cfg};
      addr_start_x:    rd_mux = {9'h000, start_x};
      addr_start_y:    rd_mux = {8'h00, start_y};
      addr_status:     rd_mux = {3'h0, state == line_read, row_address};
      default:         rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// ==== verilog/readout_path_pkg.sv ====
// Constants and types for the sensor output path and sub-sampling block.
`default_nettype none
package readout_path_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] addr_amplifier = 4'h0;
  localparam logic [3:0] addr_gain      = 4'h1;
  localparam logic [3:0] addr_dac_coarse = 4'h2;
  localparam logic [3:0] addr_dac_fine  = 4'h3;
  localparam logic [3:0] addr_dac_dark  = 4'h4;
  localparam logic [3:0] addr_core      = 4'h5;
  localparam logic [3:0] addr_start_x   = 4'h6;
  localparam logic [3:0] addr_start_y   = 4'h7;
  localparam logic [3:0] addr_status    = 4'h8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int amp_standby_bit = 0;
  localparam int amp_one_out_bit = 1;
  localparam int amp_calib_bit   = 2;
  localparam int amp_two_adc_bit = 3;
  localparam int core_ndr_bit    = 0;
  localparam int core_sub_lsb    = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] amp_reset     = 4'h8;
  localparam logic [3:0] gain_reset    = 4'h0;
  localparam logic [7:0] dac_reset     = 8'h00;
  localparam logic [3:0] core_reset    = 4'h0;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int block_width = 24;
  localparam int start_x_count = 99;
  localparam int start_y_count = 138;
  localparam logic [6:0] start_x_last = 7'h62;
  localparam logic [7:0] start_y_last = 8'h89;

  localparam logic [4:0] step_a = 5'h02;
  localparam logic [4:0] step_b = 5'h04;
  localparam logic [4:0] step_c = 5'h06;
  localparam logic [4:0] step_d = 5'h08;
  localparam logic [4:0] step_e = 5'h0C;

  typedef enum logic [1:0] {
    line_idle,
    line_read,
    line_skip
  } line_state_e;

endpackage

`default_nettype wire
